// ### logic/ddrmap_ctrl_end.sv
// controller end: turns user requests into activate, column and precharge commands
module ddrmap_ctrl_end
    import ddrmap_pkg::*;
(
    input  logic              core_clk_i,
    input  logic              srst_i,
    input  ddrmap_org_t       org_i,
    input  logic              req_valid_i,
    input  logic              req_write_i,
    input  logic [LIN_W-1:0]  req_addr_i,
    input  logic              req_ap_i,
    input  logic [DQ_W-1:0]   req_wdata_i,
    input  logic [LANES-1:0]  req_wmask_i,
    output logic              req_ready_o,
    input  logic              ext_valid_i,
    input  logic              ext_ros_en_i,
    output logic              ext_ready_o,
    output logic              rsp_valid_o,
    output logic [DQ_W-1:0]   rsp_rdata_o,
    output logic              ros_en_o,
    ddrmap_link_if.ctrl       link
);

    typedef enum logic [2:0] {ST_IDLE, ST_ACT, ST_COL, ST_RDCAP, ST_PRE, ST_EXT} ddrmap_cst_t;

    ddrmap_cst_t       state_q, state_d;
    ddrmap_cmd_t       cmd_q, cmd_d;
    logic [BANK_W-1:0] bank_q, bank_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DQ_W-1:0]   dq_q, dq_d;
    logic              dq_oe_q, dq_oe_d;
    logic [LANES-1:0]  stb_q, stb_d;
    logic [LANES-1:0]  wm_q, wm_d;
    logic [LIN_W-1:0]  lin_q, lin_d;
    logic              wr_q, wr_d;
    logic              ap_q, ap_d;
    logic [DQ_W-1:0]   wdata_q, wdata_d;
    logic [LANES-1:0]  umask_q, umask_d;
    logic              ros_en_q, ros_en_d;
    logic              rsp_v_q, rsp_v_d;
    logic [DQ_W-1:0]   rsp_q, rsp_d;

    logic              idle;
    logic [LIN_W-1:0]  map_in;
    logic [BANK_W-1:0] map_bank;
    logic [ADDR_W-1:0] map_row;
    logic [ADDR_W-1:0] map_col;
    logic              mask_ok;

    assign idle         = (state_q == ST_IDLE);
    assign ext_ready_o  = idle;
    assign req_ready_o  = idle && !ext_valid_i;
    assign map_in       = idle ? req_addr_i : lin_q;
    // with the read strobe on, the shared pin cannot mask, so masks are dropped
    assign mask_ok      = !(ros_en_q && org_i == ORG_X8);

    ddrmap_addr_split u_split (
        .org_i      (org_i),
        .lin_addr_i (map_in),
        .ap_i       (ap_q),
        .bank_o     (map_bank),
        .row_addr_o (map_row),
        .col_addr_o (map_col)
    );

    always_comb begin
        state_d = state_q;
        cmd_d   = CMD_NOP;
        bank_d  = bank_q;
        addr_d  = addr_q;
        dq_d    = '0;
        dq_oe_d = 1'b0;
        stb_d   = '0;
        wm_d    = '0;
        lin_d   = lin_q;
        wr_d    = wr_q;
        ap_d    = ap_q;
        wdata_d = wdata_q;
        umask_d = umask_q;
        ros_en_d = ros_en_q;
        rsp_v_d = 1'b0;
        rsp_d   = rsp_q;
        case (state_q)
            ST_IDLE: begin
                if (ext_valid_i) begin
                    cmd_d    = CMD_EXT;
                    bank_d   = EMR1_BANK;
                    addr_d   = ADDR_W'(ext_ros_en_i) << ROS_EN_BIT;
                    ros_en_d = ext_ros_en_i;
                    state_d  = ST_EXT;
                end else if (req_valid_i) begin
                    cmd_d   = CMD_ACT;
                    bank_d  = map_bank;
                    addr_d  = map_row;
                    lin_d   = req_addr_i;
                    wr_d    = req_write_i;
                    ap_d    = req_ap_i;
                    wdata_d = req_wdata_i;
                    umask_d = req_wmask_i;
                    state_d = ST_ACT;
                end
            end
            ST_ACT: begin
                cmd_d  = wr_q ? CMD_WR : CMD_RD;
                addr_d = map_col;
                if (wr_q) begin
                    dq_d    = wdata_q & dq_mask(org_i);
                    dq_oe_d = 1'b1;
                    stb_d   = lanes_of(org_i);
                    wm_d    = mask_ok ? (umask_q & lanes_of(org_i)) : '0;
                end
                state_d = ST_COL;
            end
            ST_COL: begin
                if (!wr_q) begin
                    state_d = ST_RDCAP;
                end else if (ap_q) begin
                    state_d = ST_IDLE;
                end else begin
                    cmd_d   = CMD_PRE;
                    state_d = ST_PRE;
                end
            end
            ST_RDCAP: begin
                rsp_v_d = 1'b1;
                rsp_d   = link.dq & dq_mask(org_i);
                if (ap_q) begin
                    state_d = ST_IDLE;
                end else begin
                    cmd_d   = CMD_PRE;
                    state_d = ST_PRE;
                end
            end
            ST_PRE: state_d = ST_IDLE;
            ST_EXT: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_NOP;
            bank_q  <= '0;
            addr_q  <= '0;
            dq_q    <= '0;
            dq_oe_q <= 1'b0;
            stb_q   <= '0;
            wm_q    <= '0;
            lin_q   <= '0;
            wr_q    <= 1'b0;
            ap_q    <= 1'b0;
            wdata_q <= '0;
            umask_q <= '0;
            ros_en_q <= 1'b0;
            rsp_v_q <= 1'b0;
            rsp_q   <= '0;
        end else begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            bank_q  <= bank_d;
            addr_q  <= addr_d;
            dq_q    <= dq_d;
            dq_oe_q <= dq_oe_d;
            stb_q   <= stb_d;
            wm_q    <= wm_d;
            lin_q   <= lin_d;
            wr_q    <= wr_d;
            ap_q    <= ap_d;
            wdata_q <= wdata_d;
            umask_q <= umask_d;
            ros_en_q <= ros_en_d;
            rsp_v_q <= rsp_v_d;
            rsp_q   <= rsp_d;
        end
    end

    assign link.cmd         = cmd_q;
    assign link.bank_select = bank_q;
    assign link.addr        = addr_q;
    assign link.write_mask  = wm_q;
    assign link.dq_c        = dq_q;
    assign link.dq_c_oe     = dq_oe_q;
    assign link.strobe_c    = stb_q;
    assign link.strobe_c_oe = stb_q;
    assign rsp_valid_o      = rsp_v_q;
    assign rsp_rdata_o      = rsp_q;
    assign ros_en_o         = ros_en_q;

endmodule : ddrmap_ctrl_end

// ### pkg/ddrmap_pkg.sv
// shared constants, types and decode functions for the address and strobe map
package ddrmap_pkg;

    typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} ddrmap_org_t;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_RD,
        CMD_WR,
        CMD_PRE,
        CMD_EXT
    } ddrmap_cmd_t;

    localparam int NUM_BANKS    = 8;
    localparam int BANK_W       = 3;
    localparam int ADDR_W       = 16;
    localparam int DQ_W         = 16;
    localparam int LANES        = 2;
    localparam int LANE_W       = 8;
    localparam int ROW_W        = 14;
    localparam int COL_W        = 11;
    localparam int LIN_W        = 28;
    localparam int AP_BIT       = 10;
    localparam int COL_HI_BIT   = 11;
    localparam int COL_BITS_X4  = 11;
    localparam int COL_BITS_STD = 10;
    localparam int WIDTH_X4     = 4;
    localparam int WIDTH_X8     = 8;
    localparam int WIDTH_X16    = 16;
    localparam int BYTE_BITS    = 8;
    localparam int PAGE_BYTES_W = 12;
    localparam int ROS_EN_BIT   = 11;
    localparam int MEM_ROW_IDX  = 2;
    localparam int MEM_COL_IDX  = 3;
    localparam int MEM_AW       = BANK_W + MEM_ROW_IDX + MEM_COL_IDX;
    localparam int MEM_DEPTH    = 1 << MEM_AW;

    localparam logic [BANK_W-1:0] EMR1_BANK    = 3'h1;
    localparam logic [ROW_W-1:0]  ROW_MASK_X16 = 14'h1FFF;
    localparam logic [DQ_W-1:0]   DQ_MASK_X4   = 16'h000F;
    localparam logic [DQ_W-1:0]   DQ_MASK_X8   = 16'h00FF;
    localparam logic [DQ_W-1:0]   DQ_MASK_X16  = 16'hFFFF;
    localparam logic [LANES-1:0]  LANES_ONE    = 2'h1;
    localparam logic [LANES-1:0]  LANES_BOTH   = 2'h3;

    function automatic int col_bits(ddrmap_org_t org);
        return (org == ORG_X4) ? COL_BITS_X4 : COL_BITS_STD;
    endfunction : col_bits

    function automatic int dq_width(ddrmap_org_t org);
        return (org == ORG_X4) ? WIDTH_X4 : ((org == ORG_X8) ? WIDTH_X8 : WIDTH_X16);
    endfunction : dq_width

    function automatic logic [PAGE_BYTES_W-1:0] page_bytes(ddrmap_org_t org);
        int len;
        len = 1 << col_bits(org);
        return PAGE_BYTES_W'(len * dq_width(org) / BYTE_BITS);
    endfunction : page_bytes

    function automatic logic [DQ_W-1:0] dq_mask(ddrmap_org_t org);
        return (org == ORG_X4) ? DQ_MASK_X4 : ((org == ORG_X8) ? DQ_MASK_X8 : DQ_MASK_X16);
    endfunction : dq_mask

    function automatic logic [LANES-1:0] lanes_of(ddrmap_org_t org);
        return (org == ORG_X16) ? LANES_BOTH : LANES_ONE;
    endfunction : lanes_of

    function automatic logic [COL_W-1:0] col_of(logic [ADDR_W-1:0] a, ddrmap_org_t org);
        logic hi;
        hi = (org == ORG_X4) ? a[COL_HI_BIT] : 1'b0;
        return {hi, a[AP_BIT-1:0]};
    endfunction : col_of

    function automatic logic [ROW_W-1:0] row_of(logic [ADDR_W-1:0] a, ddrmap_org_t org);
        return (org == ORG_X16) ? (a[ROW_W-1:0] & ROW_MASK_X16) : a[ROW_W-1:0];
    endfunction : row_of

endpackage : ddrmap_pkg

// ### pkg/ddrmap_link_if.sv
// link between controller end and memory end, with two-way pin resolution
interface ddrmap_link_if;
    import ddrmap_pkg::*;

    ddrmap_cmd_t       cmd;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  write_mask;
    logic [DQ_W-1:0]   dq_c;
    logic              dq_c_oe;
    logic [DQ_W-1:0]   dq_m;
    logic              dq_m_oe;
    logic [DQ_W-1:0]   dq;
    logic [LANES-1:0]  strobe_c;
    logic [LANES-1:0]  strobe_c_oe;
    logic [LANES-1:0]  strobe_m;
    logic [LANES-1:0]  strobe_m_oe;
    logic [LANES-1:0]  strobe;
    logic              read_only_strobe_m;
    logic              read_only_strobe_oe;
    logic              read_only_strobe;

    // an undriven wire reads low
    assign dq = dq_c_oe ? dq_c : (dq_m_oe ? dq_m : '0);
    assign strobe = (strobe_c & strobe_c_oe) | (strobe_m & strobe_m_oe);
    assign read_only_strobe = read_only_strobe_m & read_only_strobe_oe;

    modport ctrl (
        output cmd, bank_select, addr, write_mask, dq_c, dq_c_oe, strobe_c, strobe_c_oe,
        input  dq, strobe, read_only_strobe
    );

    modport mem (
        input  cmd, bank_select, addr, write_mask, dq, strobe,
        output dq_m, dq_m_oe, strobe_m, strobe_m_oe, read_only_strobe_m, read_only_strobe_oe
    );

endinterface : ddrmap_link_if

// ### logic/ddrmap_addr_split.sv
// splits a linear word address into bank, row and column pin fields
module ddrmap_addr_split
    import ddrmap_pkg::*;
(
    input  ddrmap_org_t       org_i,
    input  logic [LIN_W-1:0]  lin_addr_i,
    input  logic              ap_i,
    output logic [BANK_W-1:0] bank_o,
    output logic [ADDR_W-1:0] row_addr_o,
    output logic [ADDR_W-1:0] col_addr_o
);

    logic              is_x4;
    logic [COL_W-1:0]  col_raw;
    logic [LIN_W-1:0]  rest;
    logic [ROW_W-1:0]  row_raw;

    // column bits sit lowest so a page stays in one row
    assign is_x4   = (org_i == ORG_X4);
    assign col_raw = is_x4 ? lin_addr_i[COL_W-1:0] : {1'b0, lin_addr_i[AP_BIT-1:0]};
    assign rest    = is_x4 ? (lin_addr_i >> COL_BITS_X4) : (lin_addr_i >> COL_BITS_STD);
    assign bank_o  = rest[BANK_W-1:0];
    assign row_raw = rest[BANK_W +: ROW_W];

    // upper pins are left low, the far end ignores them
    assign row_addr_o = ADDR_W'(row_of(ADDR_W'(row_raw), org_i));
    assign col_addr_o = ADDR_W'({col_raw[COL_W-1], ap_i, col_raw[AP_BIT-1:0]});

endmodule : ddrmap_addr_split

// ### logic/ddrmap_mem_end.sv
// memory end: bank, row and column decode, byte masks and strobes of the device
//
// What this block does
// - eight banks in every organisation
// - column and row pins per organisation
// - pin ten selects auto-precharge on column commands
// - page size follows column bits and width
// - future address pins are ignored
// - read strobe off until extended register one
// - read strobe on disables write masking
// - read strobe accompanies read data
// - x16 has separate upper and lower strobes
// - x16 byte masks gate their own byte
// - x8 has eight lines, one strobe, one mask
// - beat dropped when mask high with it
// - bank select picks the command's bank
module ddrmap_mem_end
    import ddrmap_pkg::*;
(
    input  logic                    core_clk_i,
    input  logic                    srst_i,
    input  ddrmap_org_t             org_i,
    ddrmap_link_if.mem              link,
    output logic                    ros_en_o,
    output logic [NUM_BANKS-1:0]    bank_open_o,
    output logic [PAGE_BYTES_W-1:0] page_bytes_o
);

    // small stand-in array: the bank and only the low row and column bits index it,
    // so distinct addresses alias; enough to check the mapping and masks
    logic [DQ_W-1:0]      mem_q [MEM_DEPTH];

    logic [NUM_BANKS-1:0] open_q;
    logic [NUM_BANKS-1:0] open_d;
    logic [ROW_W-1:0]     row_q [NUM_BANKS];
    logic                 ros_en_q;
    logic                 ros_en_d;
    logic [DQ_W-1:0]      rd_data_q;
    logic                 rd_vld_q;
    logic [LANES-1:0]     rd_stb_q;
    logic                 ros_q;
    logic [PAGE_BYTES_W-1:0] page_q;

    ddrmap_cmd_t          cmd;
    logic [BANK_W-1:0]    bank;
    logic [ROW_W-1:0]     row_w;
    logic [COL_W-1:0]     col_w;
    logic                 ap_w;
    logic                 is_col;
    logic                 bank_hit;
    logic                 wr_go;
    logic                 rd_go;
    logic                 emr1_go;
    logic                 x8_ros;
    logic                 mask_on;
    logic [DQ_W-1:0]      org_mask;
    logic [LANES-1:0]     lane_we;
    logic [DQ_W-1:0]      bit_we;
    logic [MEM_AW-1:0]    idx_w;
    logic                 act_go;
    logic                 pre_go;
    logic                 ap_close;
    logic                 close_go;
    logic [DQ_W-1:0]      wr_word;
    logic [LANES-1:0]     rd_lanes;
    logic [DQ_W-1:0]      rd_word;
    logic [PAGE_BYTES_W-1:0] page_d;

    // decode of the pins on the current command
    assign cmd      = link.cmd;
    assign bank     = link.bank_select;
    // row_of drops the pin unused on x16 and never reads fourteen or fifteen
    assign row_w    = row_of(link.addr, org_i);
    // column decode skips pin ten, which is the precharge flag instead
    assign col_w    = col_of(link.addr, org_i);
    assign ap_w     = link.addr[AP_BIT];
    assign is_col   = (cmd == CMD_RD) || (cmd == CMD_WR);
    assign bank_hit = open_q[bank];
    assign wr_go    = (cmd == CMD_WR) && bank_hit;
    assign rd_go    = (cmd == CMD_RD) && bank_hit;
    assign emr1_go  = (cmd == CMD_EXT) && (bank == EMR1_BANK);

    // read strobe only exists on the x8 part
    assign x8_ros   = ros_en_q && (org_i == ORG_X8);
    // the shared pin turns into a strobe output, so it can no longer mask
    assign mask_on  = !x8_ros;

    // x4 uses a nibble, x8 a byte on lane zero, x16 both lanes
    assign org_mask = dq_mask(org_i);

    // the word index takes the row held open in the addressed bank
    assign idx_w = {bank, row_q[bank][MEM_ROW_IDX-1:0], col_w[MEM_COL_IDX-1:0]};

    // a precharge needs no hit: closing a closed bank changes nothing
    assign act_go   = (cmd == CMD_ACT);
    assign pre_go   = (cmd == CMD_PRE);
    // of the column commands, only one that reached an open bank may close it
    assign ap_close = is_col && ap_w && bank_hit;
    assign close_go = ap_close || pre_go;

    // whole word rewritten, gated bits taken from the stored copy
    assign wr_word  = (mem_q[idx_w] & ~bit_we) | (link.dq & bit_we);
    // read lanes and data formed here so the output flops stay plain
    assign rd_lanes = rd_go ? lanes_of(org_i) : '0;
    assign rd_word  = mem_q[idx_w] & org_mask;

    // the strap is static, so the size only settles after reset
    assign page_d   = page_bytes(org_i);

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            // each lane has its own strobe and its own mask
            assign lane_we[l] = link.strobe[l]
                                && !(link.write_mask[l] && mask_on);
            assign bit_we[l*LANE_W +: LANE_W] = {LANE_W{lane_we[l]}}
                                                & org_mask[l*LANE_W +: LANE_W];
        end
    endgenerate

    // bank state: activate opens, precharge or auto-precharge closes
    always_comb begin
        open_d = open_q;
        if (act_go) begin
            open_d[bank] = 1'b1;
        end
        if (close_go) begin
            open_d[bank] = 1'b0;
        end
    end

    always_comb begin
        ros_en_d = ros_en_q;
        if (emr1_go) begin
            ros_en_d = link.addr[ROS_EN_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            open_q   <= '0;
            ros_en_q <= 1'b0;
        end else begin
            open_q   <= open_d;
            ros_en_q <= ros_en_d;
        end
    end

    // open row per bank; reactivating an open bank replaces its row
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                row_q[b] <= '0;
            end
        end else if (act_go) begin
            row_q[bank] <= row_w;
        end
    end

    // write beat travels with its command and strobe in the same cycle;
    // a masked lane keeps its old contents
    always_ff @(posedge core_clk_i) begin
        if (wr_go) begin
            mem_q[idx_w] <= wr_word;
        end
    end

    // read data, lane strobes and read strobe come one cycle after the command
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_data_q <= '0;
            rd_vld_q  <= 1'b0;
            rd_stb_q  <= '0;
            ros_q     <= 1'b0;
        end else begin
            rd_vld_q  <= rd_go;
            rd_stb_q  <= rd_lanes;
            ros_q     <= rd_go && x8_ros;
            if (rd_go) begin
                rd_data_q <= rd_word;
            end
        end
    end

    // page size tracks the strap so a change shows on the next cycle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            page_q <= '0;
        end else begin
            page_q <= page_d;
        end
    end

    assign link.dq_m                = rd_data_q;
    assign link.dq_m_oe             = rd_vld_q;
    assign link.strobe_m            = rd_stb_q;
    assign link.strobe_m_oe         = rd_stb_q;
    // left undriven while disabled, so the pin stays inactive
    assign link.read_only_strobe_m  = ros_q;
    assign link.read_only_strobe_oe = ros_q;

    assign ros_en_o     = x8_ros;
    assign bank_open_o  = open_q;
    assign page_bytes_o = page_q;

endmodule : ddrmap_mem_end

// ### testbench/ddrmap_link_assertions.sv
// link checker: command order, data direction and strobe behaviour on the joined link
module ddrmap_link_assertions
    import ddrmap_pkg::*;
(
    input logic              core_clk_i,
    input logic              srst_i,
    input ddrmap_cmd_t       cmd,
    input logic [BANK_W-1:0] bank_select,
    input logic [ADDR_W-1:0] addr,
    input logic [LANES-1:0]  write_mask,
    input logic              dq_c_oe,
    input logic              dq_m_oe,
    input logic [LANES-1:0]  strobe_c_oe,
    input logic [LANES-1:0]  strobe_m_oe,
    input logic              read_only_strobe_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    // own copy of the read strobe enable, updated on the same edge as the memory end
    logic en_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            en_q <= 1'b0;
        end else if (cmd == CMD_EXT && bank_select == EMR1_BANK) begin
            en_q <= addr[ROS_EN_BIT];
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    property p_read_answer; cmd == CMD_RD |=> dq_m_oe && strobe_m_oe != '0; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data missing");
    property p_read_once; dq_m_oe |=> !dq_m_oe; endproperty
    a_read_once: assert property (p_read_once) else $error("read data held");
    property p_oe_cause; dq_m_oe |-> $past(cmd) == CMD_RD; endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("data without read");
    property p_no_fight; !(dq_c_oe && dq_m_oe); endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
    property p_write_beat; cmd == CMD_WR |-> dq_c_oe && strobe_c_oe != '0; endproperty
    a_write_beat: assert property (p_write_beat) else $error("write without beat");
    property p_ctrl_oe; dq_c_oe |-> cmd == CMD_WR; endproperty
    a_ctrl_oe: assert property (p_ctrl_oe) else $error("stray write data");
    property p_act_col;
        cmd == CMD_ACT |=> cmd inside {CMD_RD, CMD_WR} && $stable(bank_select);
    endproperty
    a_act_col: assert property (p_act_col) else $error("column bank differs");
    property p_ros_gate; read_only_strobe_oe |-> en_q && dq_m_oe; endproperty
    a_ros_gate: assert property (p_ros_gate) else $error("read strobe too early");
    property p_ros_read; en_q && dq_m_oe |-> read_only_strobe_oe; endproperty
    a_ros_read: assert property (p_ros_read) else $error("read strobe missing");
    property p_mask_drop; cmd == CMD_WR && en_q |-> write_mask == '0; endproperty
    a_mask_drop: assert property (p_mask_drop) else $error("mask with read strobe");

    c_read: cover property (cmd == CMD_RD ##1 dq_m_oe);
    c_masked: cover property (cmd == CMD_WR && write_mask != '0);
    c_ros: cover property (read_only_strobe_oe);
endmodule : ddrmap_link_assertions

// ### testbench/tb_ddr2_address_and_strobe_map.sv
// top bench: both link ends joined, reference model fed with random traffic
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end

module tb_ddr2_address_and_strobe_map
    import ddrmap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    core_clk_i = 1'b0;
    logic                    srst_i     = 1'b1;
    ddrmap_org_t             org        = ORG_X4;
    logic                    req_valid  = 1'b0;
    logic                    req_write  = 1'b0;
    logic [LIN_W-1:0]        req_addr   = '0;
    logic                    req_ap     = 1'b0;
    logic [DQ_W-1:0]         req_wdata  = '0;
    logic [LANES-1:0]        req_wmask  = '0;
    logic                    ext_valid  = 1'b0;
    logic                    ext_en     = 1'b0;
    logic                    req_ready;
    logic                    ext_ready;
    logic                    rsp_valid;
    logic [DQ_W-1:0]         rsp_rdata;
    logic                    c_ros_en;
    logic                    m_ros_en;
    logic [NUM_BANKS-1:0]    bank_open;
    logic [PAGE_BYTES_W-1:0] page_bytes;
    logic [DQ_W-1:0]         mem_q [256];
    logic [31:0]             seed       = 32'h456AD1CA;
    logic                    ros_m      = 1'b0;
    int                      n_errors   = 0;
    int                      checks     = 0;

    ddrmap_link_if link ();

    always #20 core_clk_i = ~core_clk_i;

    ddrmap_ctrl_end i_ddrmap_ctrl_end (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .org_i(org), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_addr_i(req_addr), .req_ap_i(req_ap),
        .req_wdata_i(req_wdata), .req_wmask_i(req_wmask), .req_ready_o(req_ready),
        .ext_valid_i(ext_valid), .ext_ros_en_i(ext_en), .ext_ready_o(ext_ready),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .ros_en_o(c_ros_en), .link(link)
    );

    ddrmap_mem_end i_ddrmap_mem_end (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .org_i(org), .link(link),
        .ros_en_o(m_ros_en), .bank_open_o(bank_open), .page_bytes_o(page_bytes)
    );

    ddrmap_link_assertions i_ddrmap_link_assertions (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .cmd(link.cmd),
        .bank_select(link.bank_select), .addr(link.addr), .write_mask(link.write_mask),
        .dq_c_oe(link.dq_c_oe), .dq_m_oe(link.dq_m_oe), .strobe_c_oe(link.strobe_c_oe),
        .strobe_m_oe(link.strobe_m_oe), .read_only_strobe_oe(link.read_only_strobe_oe)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic int cbits();
        return (org == ORG_X4) ? 11 : 10;
    endfunction : cbits

    function automatic logic [DQ_W-1:0] omask();
        return (org == ORG_X4) ? 16'h000F : ((org == ORG_X8) ? 16'h00FF : 16'hFFFF);
    endfunction : omask

    task automatic final_report();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // a write leaves the request up so back-to-back calls never toggle it; a read
    // drops it at the take, or the idle cycle that comes with its response would take it again
    task automatic op(input logic wr, input logic [LIN_W-1:0] a, input logic [LANES-1:0] m);
        logic [DQ_W-1:0]  d;
        logic [LANES-1:0] eff;
        logic [2:0]       b;
        logic             ap;
        int               i;
        void'(rnd());
        d = seed[15:0];
        ap = seed[16];
        b = 3'(a >> cbits());
        i = int'(b) * 32 + int'((a >> (cbits() + 3)) & 3) * 8 + int'(a & 7);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_ap <= ap;
        req_wdata <= d;
        req_wmask <= m;
        do @(posedge core_clk_i); while (req_ready !== 1'b1);
        // narrow parts use lane 0 only; the read strobe switches masking off on x8
        eff = (org == ORG_X16) ? ~m : {1'b0, ~m[0] | (ros_m && org == ORG_X8)};
        if (wr) begin
            for (int l = 0; l < LANES; l++) begin
                if (eff[l]) begin
                    mem_q[i][l*8+:8] = d[l*8+:8];
                end
            end
        end else begin
            req_valid <= 1'b0;
            do @(posedge core_clk_i); while (rsp_valid !== 1'b1);
            `CHK(rsp_rdata, mem_q[i] & omask())
            `CHK(bank_open, ap ? 8'h00 : 8'h01 << b)
        end
    endtask : op

    task automatic rand_op();
        void'(rnd());
        op(seed[0], LIN_W'(seed >> 4), seed[2:1]);
    endtask : rand_op

    task automatic ext_mode(input logic en);
        req_valid <= 1'b0;
        ext_valid <= 1'b1;
        ext_en <= en;
        do @(posedge core_clk_i); while (ext_ready !== 1'b1);
        ext_valid <= 1'b0;
        ros_m = en;
        repeat (3) @(posedge core_clk_i);
        `CHK(c_ros_en, en)
        `CHK(m_ros_en, en)
    endtask : ext_mode

    task automatic phase(input ddrmap_org_t o, input int n);
        int c;
        req_valid <= 1'b0;
        // drain a request in flight; the reset at the start follows straight on
        if (!srst_i) repeat (6) @(posedge core_clk_i);
        org <= o;
        srst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        ros_m = 1'b0;
        c = cbits();
        `CHK(page_bytes, PAGE_BYTES_W'((1 << c) * (c == 11 ? 4 : (o == ORG_X8 ? 8 : 16)) / 8))
        `CHK(m_ros_en, 1'b0)
        // every model slot is written first so no read ever meets an unknown word
        for (int k = 0; k < 256; k++) begin
            op(1'b1, LIN_W'((k & 7) | ((k >> 5) << c) | (((k >> 3) & 3) << (c + 3))), 2'h0);
        end
        repeat (n) rand_op();
    endtask : phase

    initial begin
        phase(ORG_X4, 100);
        phase(ORG_X8, 60);
        ext_mode(1'b1);
        repeat (60) rand_op();
        ext_mode(1'b0);
        repeat (30) rand_op();
        phase(ORG_X16, 100);
        final_report();
    end

    initial begin
        repeat (30000) @(posedge core_clk_i);
        n_errors++;
        final_report();
    end
endmodule : tb_ddr2_address_and_strobe_map
